/* logic/edge_sync.sv */
// two-flop synchroniser with edge detection for the link pins
`timescale 1ns/1ns
module edge_sync
#(
  // level the pin rests at; resetting to it keeps a false edge from following reset
  parameter logic IDLE_LEVEL = 1'b0
)
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // pin side
  input  wire logic pin_in,
  // synchronised level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= IDLE_LEVEL;
      sync_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule // edge_sync

/* logic/quad_dac_serial_frame_decoder.sv */
// serial frame decoder for a four-channel output converter
//
// Behaviour
// - 24-bit frame MSB first: rw, zero, reg type[21:19], channel[18:16], data[15:0].
// - bit 23 high requests a read, low requests a write.
// - register type 000 function, 010 data, 011 coarse gain, 100 fine gain.
// - channel 000 A, 001 B, 010 C, 011 D, 100 all four.
// - register type 000 always routes the frame to the function register.
// - function frames use the channel bits as function code; data bits go to wr_data_out.
// - read frame has rw set; its data bits are ignored.
// - frame after a read shifts previous target out on serial output.
`timescale 1ns/1ns
module quad_dac_serial_frame_decoder
  import frame_decoder_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // serial link pins
  input  wire logic        sclk_in,
  input  wire logic        sync_n_in,
  input  wire logic        serial_in_pin_in,
  output logic             serial_out_pin_out,
  // decoded frame
  output logic             wr_strobe_out,
  output logic [3:0]       wr_target_out,
  output logic [3:0]       wr_chan_mask_out,
  output logic [2:0]       func_code_out,
  output logic [15:0]      wr_data_out,
  output logic             frame_error_out,
  // readback select to and data from the register bank
  output logic [3:0]       rd_target_out,
  output logic [1:0]       rd_chan_out,
  input  wire logic [15:0] rd_data_in
);
  logic sclk_rise, sclk_fall;
  logic sync_lvl, sync_rise, sync_fall;
  logic sdi_lvl;

  // link clock idles low
  edge_sync #(.IDLE_LEVEL(1'b0)) u_sclk (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(sclk_in),
                    .level_out(), .rise_out(sclk_rise), .fall_out(sclk_fall));
  // sync idles high, so reset must not fake a frame end
  edge_sync #(.IDLE_LEVEL(1'b1)) u_sync (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(sync_n_in),
                    .level_out(sync_lvl), .rise_out(sync_rise), .fall_out(sync_fall));
  edge_sync #(.IDLE_LEVEL(1'b0)) u_sdi  (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(serial_in_pin_in),
                    .level_out(sdi_lvl), .rise_out(), .fall_out());

  logic [FRAME_BITS-1:0] shift_q;
  logic [CNT_BITS-1:0]   count_q;
  logic [FRAME_BITS-1:0] out_q;
  logic                  read_pend_q;
  logic                  sdo_q;

  // map the three register bits to a one-hot target, zero when unlisted
  function automatic logic [3:0] decode_reg(input logic [2:0] code);
    case (code)
      REG_FUNCTION: decode_reg = TGT_FUNCTION;
      REG_DATA:     decode_reg = TGT_DATA;
      REG_COARSE:   decode_reg = TGT_COARSE;
      REG_FINE:     decode_reg = TGT_FINE;
      default:      decode_reg = 4'h0;
    endcase
  endfunction

  // map the three channel bits to a channel mask, zero when unlisted
  function automatic logic [3:0] decode_chan(input logic [2:0] code);
    case (code)
      CHAN_A:   decode_chan = 4'h1;
      CHAN_B:   decode_chan = 4'h2;
      CHAN_C:   decode_chan = 4'h4;
      CHAN_D:   decode_chan = 4'h8;
      CHAN_ALL: decode_chan = 4'hf;
      default:  decode_chan = 4'h0;
    endcase
  endfunction

  logic       frame_active;
  logic       frame_rw;
  logic       frame_zero;
  logic [2:0] frame_reg;
  logic [2:0] frame_chan;
  logic [3:0] tgt;
  logic [3:0] cmask;
  logic       is_func;
  logic       frame_ok;
  logic       frame_done;

  assign frame_active = ~sync_lvl;
  assign frame_rw   = shift_q[BIT_RW];
  assign frame_zero = shift_q[BIT_ZERO];
  assign frame_reg  = shift_q[REG_MSB:REG_LSB];
  assign frame_chan = shift_q[CHAN_MSB:CHAN_LSB];
  assign tgt   = decode_reg(frame_reg);
  assign cmask = decode_chan(frame_chan);
  // type zero is the function register
  assign is_func = (frame_reg == REG_FUNCTION);
  // function frames skip the channel check; others need a listed channel
  assign frame_ok = (tgt != 4'h0) && !frame_zero && (is_func || cmask != 4'h0);
  // only a frame of exactly 24 clocks is latched
  assign frame_done = sync_rise && (count_q == FRAME_COUNT);

  // shift in on falling link clock while sync is low
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shift_q <= '0;
      count_q <= '0;
    end
    else if (sync_fall)
    begin
      count_q <= '0;
    end
    else if (frame_active && sclk_fall)
    begin
      shift_q <= {shift_q[FRAME_BITS-2:0], sdi_lvl};
      // saturate so longer bursts are rejected, not wrapped
      if (count_q != '1)
        count_q <= count_q + 5'h01;
    end
  end

  // write decode and function steering
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_strobe_out    <= 1'b0;
      wr_target_out    <= 4'h0;
      wr_chan_mask_out <= 4'h0;
      func_code_out    <= 3'h0;
      wr_data_out      <= REG_RESET;
      frame_error_out  <= 1'b0;
    end
    else
    begin
      wr_strobe_out <= 1'b0;
      if (sync_rise)
        frame_error_out <= !frame_done || !frame_ok;
      if (frame_done && frame_ok && !frame_rw)
      begin
        wr_strobe_out    <= 1'b1;
        wr_target_out    <= tgt;
        wr_data_out      <= shift_q[DATA_BITS-1:0];
        // function code is channel bits, not a channel
        wr_chan_mask_out <= is_func ? 4'h0 : cmask;
        func_code_out    <= is_func ? frame_chan : 3'h0;
      end
    end
  end

  // read request capture
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      read_pend_q   <= 1'b0;
      rd_target_out <= 4'h0;
      rd_chan_out   <= 2'h0;
    end
    else if (frame_done)
    begin
      read_pend_q <= frame_rw && frame_ok;
      if (frame_rw && frame_ok)
      begin
        rd_target_out <= tgt;
        // all-channel reads return channel A
        rd_chan_out   <= frame_chan[2] ? 2'h0 : frame_chan[1:0];
      end
    end
  end

  // readback shifts out during the next frame
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      out_q <= '0;
      sdo_q <= 1'b0;
    end
    else if (sync_fall)
    begin
      out_q <= read_pend_q ? {8'h00, rd_data_in} : '0;
      sdo_q <= 1'b0;
    end
    else if (frame_active && sclk_rise)
    begin
      sdo_q <= out_q[FRAME_BITS-1];
      out_q <= {out_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign serial_out_pin_out = sdo_q;
endmodule // quad_dac_serial_frame_decoder

/* pkg/frame_decoder_pkg.sv */
// constants for the quad converter serial frame decoder
package frame_decoder_pkg;
  localparam int FRAME_BITS    = 24;
  localparam int DATA_BITS     = 16;
  localparam int BIT_RW        = 23;
  localparam int BIT_ZERO      = 22;
  localparam int REG_MSB       = 21;
  localparam int REG_LSB       = 19;
  localparam int CHAN_MSB      = 18;
  localparam int CHAN_LSB      = 16;
  localparam int NUM_CHANNELS  = 4;
  localparam int CNT_BITS      = 5;
  localparam logic [2:0] REG_FUNCTION = 3'h0;
  localparam logic [2:0] REG_DATA     = 3'h2;
  localparam logic [2:0] REG_COARSE   = 3'h3;
  localparam logic [2:0] REG_FINE     = 3'h4;
  localparam logic [2:0] CHAN_A       = 3'h0;
  localparam logic [2:0] CHAN_B       = 3'h1;
  localparam logic [2:0] CHAN_C       = 3'h2;
  localparam logic [2:0] CHAN_D       = 3'h3;
  localparam logic [2:0] CHAN_ALL     = 3'h4;
  localparam logic [4:0] FRAME_COUNT  = 5'h18;
  localparam logic [15:0] REG_RESET   = 16'h0000;

  typedef enum logic [3:0] {
    TGT_FUNCTION = 4'h1,
    TGT_DATA     = 4'h2,
    TGT_COARSE   = 4'h4,
    TGT_FINE     = 4'h8
  } target_t;
endpackage

/* tb/frame_decoder_asserts.sv */
// concurrent checks on the frame decoder ports
`timescale 1ns/1ns
module frame_decoder_asserts
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // watched pins
  input wire logic        sync_n_in,
  input wire logic        wr_strobe_out,
  input wire logic [3:0]  wr_target_out,
  input wire logic [3:0]  wr_chan_mask_out,
  input wire logic [2:0]  func_code_out,
  input wire logic [15:0] wr_data_out,
  input wire logic        frame_error_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_sync_done;
    sync_n_in && $past(sync_n_in) && $past(sync_n_in, 2);
  endsequence
  a_strobe_after_sync: assert property (wr_strobe_out |-> s_sync_done)
    else $error("strobe without sync rise");
  a_strobe_single: assert property (wr_strobe_out |=> !wr_strobe_out [*2])
    else $error("strobe longer than one cycle");
  a_good_frame: assert property (wr_strobe_out |-> !frame_error_out)
    else $error("strobe on bad frame");
  a_target_onehot: assert property (wr_strobe_out |-> $onehot(wr_target_out))
    else $error("target not one-hot");
  a_func_mask: assert property (wr_strobe_out && wr_target_out == 4'h1 |-> wr_chan_mask_out == 4'h0)
    else $error("function write with channel mask");
  a_chan_mask: assert property (wr_strobe_out && wr_target_out != 4'h1 |->
    ($onehot(wr_chan_mask_out) || wr_chan_mask_out == 4'hf) && func_code_out == 3'h0)
    else $error("bad channel mask");
  a_data_hold: assert property ($changed(wr_data_out) |-> wr_strobe_out)
    else $error("data changed without strobe");
  a_error_at_end: assert property ($changed(frame_error_out) |-> sync_n_in && $past(sync_n_in))
    else $error("error changed inside frame");
endmodule // frame_decoder_asserts
bind quad_dac_serial_frame_decoder frame_decoder_asserts i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .sync_n_in(sync_n_in), .wr_strobe_out(wr_strobe_out), .wr_target_out(wr_target_out),
  .wr_chan_mask_out(wr_chan_mask_out), .func_code_out(func_code_out), .wr_data_out(wr_data_out),
  .frame_error_out(frame_error_out));

/* tb/frame_host_model.sv */
// serial host model sending command frames
`timescale 1ns/1ns
module frame_host_model
(
  input  wire logic        clk_in,
  input  wire logic        start_in,
  input  wire logic [23:0] frame_in,
  input  wire logic [4:0]  nbits_in,
  input  wire logic        sdo_in,
  output logic             sclk_out = 1'b0,
  output logic             sync_n_out = 1'b1,
  output logic             serial_in_pin_out = 1'b0,
  output logic             busy_out = 1'b0,
  output logic [23:0]      rx_out = 24'h000000
);
  int cnt;
  always @(posedge clk_in)
  begin
    if (start_in && !busy_out)
    begin
      busy_out <= 1'b1;
      sync_n_out <= 1'b0;
      cnt <= 0;
    end
    else if (busy_out)
    begin
      cnt <= cnt + 1;
      // msb first, one pulse a bit
      if (cnt >= 8 && cnt < 8 + 16 * nbits_in && (cnt - 8) % 16 == 0)
      begin
        sclk_out <= 1'b1;
        serial_in_pin_out <= frame_in[23 - (cnt - 8) / 16];
      end
      if (cnt >= 8 && cnt < 8 + 16 * nbits_in && (cnt - 8) % 16 == 8)
      begin
        sclk_out <= 1'b0;
        rx_out <= {rx_out[22:0], sdo_in};
      end
      if (cnt == 16 + 16 * nbits_in)
      begin
        sync_n_out <= 1'b1;
        serial_in_pin_out <= ~serial_in_pin_out;
      end
      if (cnt == 28 + 16 * nbits_in)
        busy_out <= 1'b0;
    end
  end
endmodule // frame_host_model

/* tb/tb_quad_dac_serial_frame_decoder.sv */
// self-checking bench for the frame decoder
`timescale 1ns/1ns
module tb_quad_dac_serial_frame_decoder;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, go = 1'b0;
  logic [23:0] frm = 24'h0, rx;
  logic [4:0]  nb = 5'h18;
  logic [15:0] rdd = 16'hbeef, wd;
  logic        sclk, sync_n, sdi, serial_out_pin, stb, err, busy;
  logic [3:0]  tgt, msk, rtg;
  logic [2:0]  fc;
  logic [1:0]  rch;
  int          num_errors = 0, check_count = 0, strobes = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  frame_host_model i_host (.clk_in, .start_in(go), .frame_in(frm), .nbits_in(nb), .sdo_in(serial_out_pin),
    .sclk_out(sclk), .sync_n_out(sync_n), .serial_in_pin_out(sdi), .busy_out(busy), .rx_out(rx));
  quad_dac_serial_frame_decoder i_dut (.clk_in, .rst_n_in, .sclk_in(sclk), .sync_n_in(sync_n),
    .serial_in_pin_in(sdi), .serial_out_pin_out(serial_out_pin), .wr_strobe_out(stb), .wr_target_out(tgt),
    .wr_chan_mask_out(msk), .func_code_out(fc), .wr_data_out(wd), .frame_error_out(err),
    .rd_target_out(rtg), .rd_chan_out(rch), .rd_data_in(rdd));
  always @(posedge clk_in)
    strobes <= strobes + (stb === 1'b1);
  always @(posedge clk_in)
    if (++cyc == 20000)
    begin
      num_errors++;
      tally_and_finish;
    end
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task send(input logic [23:0] f, input logic [4:0] n, input int s);
    int s0;
    s0 = strobes;
    frm <= f;
    nb <= n;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    while (busy) @(posedge clk_in);
    if (s >= 0) chk(strobes - s0, s);
  endtask
  task t_write;
    send(24'h11a5c3, 5'h18, 1);
    chk({tgt, msk, wd}, 24'h22a5c3);
    chk(err, 1'b0);
    send(24'h1c0f0f, 5'h18, 1);
    chk({tgt, msk}, 8'h4f);
    send(24'h230001, 5'h18, 1);
    chk({tgt, msk, wd}, 24'h880001);
    send(24'h120001, 5'h18, 1);
    chk({tgt, msk, wd}, 24'h240001);
    $display("write test done");
  endtask
  task t_func;
    send(24'h010012, 5'h18, 1);
    chk({tgt, msk, wd}, 24'h100012);
    chk(fc, 3'h1);
    $display("function test done");
  endtask
  task t_refuse;
    logic [23:0] bad [3];
    bad = '{24'h081234, 24'h521234, 24'h151234};
    foreach (bad[i])
    begin
      send(bad[i], 5'h18, 0);
      chk({err, wd}, 17'h10012);
    end
    send(24'h11a5c3, 5'h17, 0);
    chk(err, 1'b1);
    $display("refusal test done");
  endtask
  task t_read;
    send(24'ha0ffff, 5'h18, 0);
    chk({rtg, rch}, 6'h20);
    send(24'h93ffff, 5'h18, 0);
    chk({rtg, rch}, 6'h0b);
    chk(rx, {8'h00, rdd});
    send(24'h000000, 5'h18, -1);
    chk(rx, {8'h00, rdd});
    $display("read test done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk(err, 1'b0);
    t_write;
    t_func;
    t_refuse;
    t_read;
    tally_and_finish;
  end
endmodule // tb_quad_dac_serial_frame_decoder
